// [pew_pkg.sv]
// Purpose: Constants and types for the parallel EEPROM host controller
// Assumes: 50 MHz core clock, 8-bit data, 13-bit address, 32-byte page
// Notes: Command words of the lock protocol are plain defaults, set per board
package pew_pkg;
  localparam int CLK_MHZ = 50;
  localparam int AW = 13;
  localparam int DW = 8;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_LSB = 5;
  localparam int TOP_BIT = 7;
  localparam int NEXT_TOP_BIT = 6;
  // Times in their own units
  localparam int PROGRAM_TIME_MS = 5;
  localparam int LOCKOUT_MAX_MS = 10;
  localparam int WINDOW_MIN_NS = 50;
  localparam int WINDOW_MAX_US = 100;
  localparam int PULSE_MIN_NS = 150;
  localparam int READ_ACCESS_NS = 250;
  localparam int FLAG_ASSERT_DELAY_NS = 220;
  localparam int GLITCH_NS = 20;
  // Cycle counts (least times round up, longest round down)
  localparam int CYC_NS = 1000 / CLK_MHZ;
  localparam int PULSE_CYC = (PULSE_MIN_NS + CYC_NS - 1) / CYC_NS;
  localparam int ACCESS_CYC = (READ_ACCESS_NS + CYC_NS - 1) / CYC_NS;
  localparam int FLAG_CYC = (FLAG_ASSERT_DELAY_NS + CYC_NS - 1) / CYC_NS;
  localparam int GAP_CYC = (WINDOW_MIN_NS + CYC_NS - 1) / CYC_NS;
  localparam int WINDOW_CYC = WINDOW_MAX_US * CLK_MHZ;
  localparam int PROGRAM_CYC = PROGRAM_TIME_MS * 1000 * CLK_MHZ;
  localparam int LOCKOUT_CYC = LOCKOUT_MAX_MS * 1000 * CLK_MHZ;
  localparam int CW = 24;
  // Lock protocol command words, arbitrary defaults
  localparam logic [AW-1:0] CMD_ADDR_A = 13'h1555;
  localparam logic [AW-1:0] CMD_ADDR_B = 13'h0aaa;
  localparam logic [DW-1:0] CMD_DATA_A = 8'haa;
  localparam logic [DW-1:0] CMD_DATA_B = 8'h55;
  localparam logic [DW-1:0] CMD_DATA_LOCK = 8'ha0;
  localparam logic [DW-1:0] CMD_DATA_UNLK1 = 8'h80;
  localparam logic [DW-1:0] CMD_DATA_UNLK2 = 8'h20;
  localparam int LOCK_STEPS = 3;
  localparam int UNLK_STEPS = 6;
  typedef enum logic [1:0] {PEW_OP_READ, PEW_OP_WRITE, PEW_OP_LOCK, PEW_OP_UNLOCK} pew_op_e;
endpackage

// [pew_buf_if.sv]
`timescale 1ns/1ps
// Purpose: Carrier between the controller and its page buffer
// Assumes: One clock, single writer
// Notes: Read data is registered inside the buffer
interface pew_buf_if;
  import pew_pkg::*;
  logic wr_en;
  logic [PAGE_LSB-1:0] wr_idx;
  logic [PAGE_LSB-1:0] rd_idx;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] rd_data;
  modport ctl (output wr_en, wr_idx, rd_idx, wr_data, input rd_data);
  modport mem (input wr_en, wr_idx, rd_idx, wr_data, output rd_data);
endinterface

// [pew_page_mem.sv]
`timescale 1ns/1ps
// Purpose: 32-byte staging memory for page loads
// Assumes: Contents matter only between fill and drain
// Notes: Registered read port, one cycle latency
module pew_page_mem (
  // Clock
  input wire logic core_clk,
  // Access
  pew_buf_if.mem bus
);
  import pew_pkg::*;
  logic [DW-1:0] mem_reg [PAGE_BYTES];
  logic [DW-1:0] rd_reg;
  always_ff @(posedge core_clk) begin
    if (bus.wr_en) begin
      mem_reg[bus.wr_idx] <= bus.wr_data;
    end
    rd_reg <= mem_reg[bus.rd_idx];
  end
  assign bus.rd_data = rd_reg;
endmodule // pew_page_mem

// [pew_host.sv]
`timescale 1ns/1ps
// Purpose: Host controller driving a parallel EEPROM through its pins
// Assumes: Device pins asynchronous; data bus split into in, out and enable
// Notes: End of write is taken from the busy pin, a program-time timeout as a backstop
// Overview of operation
// R1: Read: strobe high, gate and select low
// R2: Device floats bus when gate or select high
// R3: Write needs select, strobe low, gate high
// R4: Address held through the later falling edge
// R5: Data held through the first rising edge
// R6: Byte programming completes within program time
// R7: Page load takes one to thirty-two bytes
// R8: Page number from upper bits, last edge
// R9: Byte within page from low five bits
// R10: Device timer restarts each rising strobe edge
// R11: Next load inside window, then strobe high
// R12: Only loaded bytes of page change
// R13: Polling returns inverted top bit while busy
// R14: Next-top bit toggles each read while busy
// R15: Open-drain busy pin low during programming
// R16: Strobe pulses under glitch width are ignored
// R17: Writes blocked during power-up lockout
// R18: Writes inhibited by gate low, select/strobe high
// R19: Lock: three command writes, page timing
// R20: Lock persists over power cycles
// R21: Unlock: six command writes return normal mode
// R22: Device ships unlocked
// R23: Locked device drops unprefixed writes
// R24: Command words are configurable constants
module pew_host #(
  parameter int PROGRAM_CYCLES = pew_pkg::PROGRAM_CYC,
  parameter int LOCKOUT_CYCLES = pew_pkg::LOCKOUT_CYC,
  parameter int WINDOW_CYCLES = pew_pkg::WINDOW_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // User command port
  input wire logic req_valid,
  output logic req_ready,
  input wire pew_pkg::pew_op_e req_op,
  input wire logic [pew_pkg::AW-1:0] req_addr,
  input wire logic [5:0] req_len,
  input wire logic locked_mode,
  // Page fill port, bytes staged before a write request
  input wire logic fill_valid,
  input wire logic [pew_pkg::PAGE_LSB-1:0] fill_idx,
  input wire logic [pew_pkg::DW-1:0] fill_data,
  // Answer
  output logic rsp_valid,
  output logic [pew_pkg::DW-1:0] rsp_data,
  output logic rsp_timeout,
  // Device pins
  output logic [pew_pkg::AW-1:0] mem_addr,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n,
  input wire logic [pew_pkg::DW-1:0] data_in,
  output logic [pew_pkg::DW-1:0] data_out,
  output logic data_oe,
  input wire logic ready_n_busy
);
  import pew_pkg::*;
  typedef enum {S_LOCKOUT, S_IDLE, S_RD, S_WLOW, S_WHIGH, S_SETTLE, S_POLL} pew_state_e;
  typedef struct packed {
    pew_state_e st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] wait_cnt;
    logic [5:0] step;
    logic [5:0] nsteps;
    logic [AW-1:0] addr;
    logic [AW-1:0] base;
    logic [DW-1:0] dout;
    logic [DW-1:0] last;
    logic ce_n, oe_n, we_n, oe, rv, to;
    logic [DW-1:0] rdata;
    logic is_write;
  } pew_state_s;
  pew_state_s s_reg, s_next;
  logic rst_m, rst_s;
  logic [DW-1:0] din_m, din_s;
  logic busy_m, busy_s;
  pew_buf_if buf_bus();
  pew_page_mem u_mem (.core_clk(core_clk), .bus(buf_bus));
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end
  // Pins are asynchronous: two stages before use
  always_ff @(posedge core_clk or negedge rst_s) begin
    if (!rst_s) begin
      din_m <= 8'h00;
      din_s <= 8'h00;
      busy_m <= 1'b1;
      busy_s <= 1'b1;
    end else begin
      din_m <= data_in;
      din_s <= din_m;
      busy_m <= ready_n_busy;
      busy_s <= busy_m;
    end
  end
  assign buf_bus.wr_en = fill_valid;
  assign buf_bus.wr_idx = fill_idx;
  assign buf_bus.wr_data = fill_data;
  // Command prefix steps come first, then the payload bytes
  function automatic logic [AW+DW-1:0] cmd_word(input pew_op_e op, input logic [5:0] k);
    logic [DW-1:0] d;
    d = CMD_DATA_A;
    if (k == 6'd1 || k == 6'd4) d = CMD_DATA_B;
    if (k == 6'd2) d = (op == PEW_OP_UNLOCK) ? CMD_DATA_UNLK1 : CMD_DATA_LOCK;
    if (k == 6'd5) d = CMD_DATA_UNLK2;
    return {(k == 6'd1 || k == 6'd4) ? CMD_ADDR_B : CMD_ADDR_A, d}; // R24
  endfunction
  pew_op_e req_op_q;
  logic prefix;
  logic [5:0] pre_n;
  always_comb begin
    s_next = s_reg;
    s_next.rv = 1'b0;
    pre_n = (s_reg.is_write && locked_mode) ? 6'(LOCK_STEPS) : 6'd0; // R23
    if (s_reg.nsteps == 6'(UNLK_STEPS) && !s_reg.is_write) pre_n = 6'(UNLK_STEPS);
    if (s_reg.nsteps == 6'(LOCK_STEPS) && !s_reg.is_write) pre_n = 6'(LOCK_STEPS);
    prefix = s_reg.step < pre_n;
    buf_bus.rd_idx = PAGE_LSB'(s_reg.step - pre_n);
    unique case (s_reg.st)
      S_LOCKOUT: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt >= CW'(LOCKOUT_CYCLES)) s_next.st = S_IDLE; // R17
      end
      S_IDLE: begin
        // Stale step counts of the last command must not pick the first payload byte
        buf_bus.rd_idx = '0;
        s_next.cnt = '0;
        s_next.step = '0;
        if (req_valid) begin
          s_next.addr = req_addr;
          s_next.base = req_addr;
          s_next.to = 1'b0;
          s_next.is_write = (req_op == PEW_OP_WRITE);
          if (req_op == PEW_OP_READ) begin
            s_next.ce_n = 1'b0; // R1
            s_next.oe_n = 1'b0;
            s_next.st = S_RD;
          end else begin
            s_next.nsteps = (req_op == PEW_OP_WRITE) ? req_len :
              (req_op == PEW_OP_LOCK) ? 6'(LOCK_STEPS) : 6'(UNLK_STEPS); // R19 R21
            if (req_op == PEW_OP_WRITE && req_len == 6'd0) s_next.nsteps = 6'd1; // R7
            if (req_op == PEW_OP_WRITE && locked_mode) begin
              s_next.nsteps = s_next.nsteps + 6'(LOCK_STEPS); // R23
            end
            s_next.st = S_SETTLE;
            s_next.oe_n = 1'b1; // R18
          end
        end
      end
      S_RD: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == CW'(ACCESS_CYC + 2)) begin
          s_next.rdata = din_s;
          s_next.rv = 1'b1;
          s_next.ce_n = 1'b1; // R2
          s_next.oe_n = 1'b1;
          s_next.st = S_IDLE;
        end
      end
      S_SETTLE: begin
        // Gate is high and buffer read data has landed before the strobe falls
        {s_next.addr, s_next.dout} = prefix ? cmd_word(req_op_q, s_reg.step) :
          {s_reg.base[AW-1:PAGE_LSB], PAGE_LSB'(s_reg.step - pre_n), buf_bus.rd_data}; // R8 R9
        s_next.ce_n = 1'b0;
        s_next.we_n = 1'b0; // R3 R4
        s_next.oe = 1'b1;
        s_next.cnt = '0;
        s_next.st = S_WLOW;
      end
      S_WLOW: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == CW'(PULSE_CYC)) begin
          s_next.we_n = 1'b1; // R5 R16
          s_next.ce_n = 1'b1;
          s_next.last = s_reg.dout;
          s_next.cnt = '0;
          s_next.step = s_reg.step + 1'b1;
          s_next.st = S_WHIGH;
        end
      end
      S_WHIGH: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        s_next.oe = 1'b0;
        if (s_reg.step != s_reg.nsteps && s_reg.cnt >= CW'(GAP_CYC)) begin
          s_next.st = S_SETTLE; // R11
        end else if (s_reg.step == s_reg.nsteps && s_reg.cnt == CW'(WINDOW_CYCLES)) begin
          s_next.cnt = '0;
          s_next.wait_cnt = '0;
          s_next.st = S_POLL; // R10 R11
        end
      end
      S_POLL: begin
        // Busy pin is low while programming; it asserts within the flag delay
        s_next.wait_cnt = s_reg.wait_cnt + 1'b1;
        if (s_reg.wait_cnt > CW'(FLAG_CYC + 2) && busy_s) begin // R15
          s_next.rv = 1'b1;
          s_next.rdata = s_reg.last;
          s_next.st = S_IDLE;
        end else if (s_reg.wait_cnt >= CW'(PROGRAM_CYCLES)) begin // R6
          s_next.to = 1'b1;
          s_next.rv = 1'b1;
          s_next.st = S_IDLE;
        end
      end
      default: s_next.st = S_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_s) begin
    if (!rst_s) begin
      req_op_q <= PEW_OP_READ;
    end else if (s_reg.st == S_IDLE && req_valid) begin
      req_op_q <= req_op;
    end
  end
  always_ff @(posedge core_clk or negedge rst_s) begin
    if (!rst_s) begin
      s_reg <= '{st: S_LOCKOUT, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign req_ready = (s_reg.st == S_IDLE);
  assign rsp_valid = s_reg.rv;
  assign rsp_data = s_reg.rdata;
  assign rsp_timeout = s_reg.to;
  assign mem_addr = s_reg.addr;
  assign chip_sel_n = s_reg.ce_n;
  assign out_gate_n = s_reg.oe_n;
  assign wr_strobe_n = s_reg.we_n;
  assign data_out = s_reg.dout;
  assign data_oe = s_reg.oe;
  // Checks on what the controller drives
  property p_no_write_gate_low;
    @(posedge core_clk) disable iff (!rst_s) !wr_strobe_n |-> out_gate_n;
  endproperty
  a_no_write_gate_low: assert property (p_no_write_gate_low) else $error("strobe with gate low"); // R18
  property p_read_strobe_high;
    @(posedge core_clk) disable iff (!rst_s) !out_gate_n |-> wr_strobe_n;
  endproperty
  a_read_strobe_high: assert property (p_read_strobe_high) else $error("read with strobe low"); // R1
  property p_no_drive_on_read;
    @(posedge core_clk) disable iff (!rst_s) !out_gate_n |-> !data_oe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus fight on read"); // R2
  sequence q_fall;
    $fell(wr_strobe_n);
  endsequence
  property p_pulse_width;
    @(posedge core_clk) disable iff (!rst_s) q_fall |-> !wr_strobe_n [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("strobe pulse too short"); // R16 R3
  property p_addr_stable;
    @(posedge core_clk) disable iff (!rst_s) !wr_strobe_n && !$past(wr_strobe_n) |-> $stable(mem_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in pulse"); // R4
  property p_data_hold;
    @(posedge core_clk) disable iff (!rst_s) $rose(wr_strobe_n) |-> data_oe && $stable(data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at rise"); // R5
  property p_no_write_lockout;
    @(posedge core_clk) disable iff (!rst_s) s_reg.st == S_LOCKOUT |-> wr_strobe_n && chip_sel_n;
  endproperty
  a_no_write_lockout: assert property (p_no_write_lockout) else $error("write in lockout"); // R17
  property p_select_with_strobe;
    @(posedge core_clk) disable iff (!rst_s) !wr_strobe_n |-> !chip_sel_n;
  endproperty
  a_select_with_strobe: assert property (p_select_with_strobe) else $error("strobe without select"); // R3
  property p_ready_only_idle;
    @(posedge core_clk) disable iff (!rst_s) req_ready |-> wr_strobe_n && chip_sel_n;
  endproperty
  a_ready_only_idle: assert property (p_ready_only_idle) else $error("ready while active"); // R11
endmodule // pew_host

// [pew_dev_model.sv]
`timescale 1ns/1ps
// Purpose: Pin-level model of the parallel EEPROM seen by the host
// Assumes: Window and program times scaled to host clock cycles; lockout and glitch times in ns
// Notes: A released bus shows the inverse of its last value
module pew_dev_model #(
  parameter int WIN_CYC = 50,
  parameter int PROG_CYC = 100,
  parameter int LOCKOUT_NS = 500
) (
  // Clock
  input wire logic core_clk,
  // Host pins
  input wire logic [pew_pkg::AW-1:0] mem_addr,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  input wire logic [pew_pkg::DW-1:0] bus_in,
  output logic [pew_pkg::DW-1:0] bus_out,
  output logic busy_n,
  // Test control
  input wire logic slow,
  output logic protect
);
  import pew_pkg::*;
  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] qa [$];
  logic [DW-1:0] qd [$];
  logic [AW-1:0] lat_a;
  logic [AW-1:0] last_a = '0;
  logic [DW-1:0] last_d = '0;
  logic [DW-1:0] last_bus = '0;
  logic toggle = 1'b0;
  logic loading = 1'b0;
  int idle = 0;
  int prog = 0;
  time t_fall = 0;
  wire wr_act = !chip_sel_n && !wr_strobe_n && out_gate_n;
  wire rd_act = !chip_sel_n && !out_gate_n && wr_strobe_n;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    protect = 1'b0;
    busy_n = 1'b1;
  end
  // Address and strobes settle in one step; wait for it before latching
  always @(posedge wr_act) begin
    t_fall = $time;
    #1 lat_a = mem_addr;
  end
  // Short pulses, lockout and busy time load nothing
  always @(negedge wr_act) begin
    if ($time - t_fall >= GLITCH_NS && $time >= LOCKOUT_NS && prog == 0) begin
      qa.push_back(lat_a);
      qd.push_back(bus_in);
      loading = 1'b1;
      idle = 0;
      busy_n = 1'b0;
    end
  end
  function automatic logic cmd_at(int s, logic [DW-1:0] d);
    return qa[s] == CMD_ADDR_A && qd[s] == CMD_DATA_A && qa[s+1] == CMD_ADDR_B
      && qd[s+1] == CMD_DATA_B && qa[s+2] == CMD_ADDR_A && qd[s+2] == d;
  endfunction
  task automatic commit();
    logic lk;
    logic ul;
    int k;
    lk = qa.size() >= 3 && cmd_at(0, CMD_DATA_LOCK);
    ul = qa.size() == 6 && cmd_at(0, CMD_DATA_UNLK1) && cmd_at(3, CMD_DATA_UNLK2);
    k = lk ? LOCK_STEPS : 0;
    if (ul) protect = 1'b0;
    if (lk) protect = 1'b1;
    if (!ul && (lk || !protect)) begin
      for (int i = k; i < qa.size(); i++) begin
        last_a = {qa[$][AW-1:PAGE_LSB], qa[i][PAGE_LSB-1:0]};
        last_d = qd[i];
        mem[last_a] = last_d;
      end
    end
    qa.delete();
    qd.delete();
    loading = 1'b0;
    prog = slow ? 3 * PROG_CYC : PROG_CYC;
  endtask
  always @(posedge core_clk) begin
    if (rd_act) last_bus = bus_out;
    if (prog > 0) begin
      prog = prog - 1;
      if (prog == 0) busy_n = 1'b1;
    end else if (loading && wr_strobe_n) begin
      idle = idle + 1;
      if (idle >= WIN_CYC) commit();
    end
  end
  always @(negedge out_gate_n) if (prog > 0) toggle = ~toggle;
  always @* begin
    if (!rd_act) bus_out = ~last_bus;
    else if (prog > 0 && mem_addr == last_a) bus_out = {~last_d[TOP_BIT], toggle, ~last_d[5:0]};
    else bus_out = mem[mem_addr];
  end
endmodule // pew_dev_model

// [pew_tb.sv]
`timescale 1ns/1ps
// Purpose: Self-checking bench for the parallel EEPROM host controller
// Assumes: Shortened program, lockout and window counts
// Notes: A shadow copy of the array holds every expected byte
module testbench;
  import pew_pkg::*;
  localparam int LOCK_C = 20;
  logic core_clk, rstn, req_valid, req_ready, locked_mode, fill_valid, rsp_valid, rsp_timeout;
  pew_op_e req_op;
  logic [AW-1:0] req_addr, mem_addr;
  logic [5:0] req_len;
  logic [PAGE_LSB-1:0] fill_idx;
  logic [DW-1:0] fill_data, rsp_data, data_out, data_in, dev_bus;
  logic chip_sel_n, out_gate_n, wr_strobe_n, data_oe, ready_n_busy, slow, protect;
  logic [DW-1:0] shadow [2**AW];
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  assign data_in = data_oe ? data_out : dev_bus;
  pew_host #(.PROGRAM_CYCLES(400), .LOCKOUT_CYCLES(LOCK_C), .WINDOW_CYCLES(60)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_len(req_len), .locked_mode(locked_mode),
    .fill_valid(fill_valid), .fill_idx(fill_idx), .fill_data(fill_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
    .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .wr_strobe_n(wr_strobe_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ready_n_busy(ready_n_busy));
  pew_dev_model i_dev (
    .core_clk(core_clk), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .bus_in(data_in),
    .bus_out(dev_bus), .busy_n(ready_n_busy), .slow(slow), .protect(protect));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Ceiling well above the longest expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_req(input pew_op_e op, input logic [AW-1:0] a, input logic [5:0] n,
                        input logic lk);
    int w;
    w = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_len <= n;
    locked_mode <= lk;
    @(posedge core_clk);
    while (req_ready !== 1'b1 && w < 50) begin
      @(posedge core_clk);
      w++;
    end
    req_valid <= 1'b0;
    w = 0;
    while (rsp_valid !== 1'b1 && w < 3000) begin
      @(posedge core_clk);
      w++;
    end
    chk({7'h0, rsp_valid}, 8'h01);
  endtask
  task automatic rd_chk(input logic [AW-1:0] a);
    do_req(PEW_OP_READ, a, 6'h01, 1'b0);
    chk(rsp_data, shadow[a]);
  endtask
  // Loads n bytes, then reads them back with the first unloaded neighbour when n is below 32
  task automatic wr_pg(input logic [AW-1:0] base, input int n, input logic [DW-1:0] seed,
                       input logic lk, input logic keep);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      fill_valid <= 1'b1;
      fill_idx <= i[PAGE_LSB-1:0];
      fill_data <= seed + i[DW-1:0];
      if (keep) shadow[AW'(base + i)] = seed + i[DW-1:0];
    end
    @(posedge core_clk);
    fill_valid <= 1'b0;
    do_req(PEW_OP_WRITE, base, n[5:0], lk);
    chk({7'h0, rsp_timeout}, 8'h00);
    for (int i = 0; i <= n && i < PAGE_BYTES; i++) rd_chk(AW'(base + i));
  endtask
  task automatic t_reset();
    int n;
    n = 0;
    repeat (16) @(posedge core_clk);
    chk({chip_sel_n, wr_strobe_n, out_gate_n, data_oe, req_ready, protect, 2'h0}, 8'he0);
    rstn <= 1'b1;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk(8'(n > LOCK_C && n <= LOCK_C + 8), 8'h01);
  endtask
  task automatic t_lock();
    do_req(PEW_OP_LOCK, 13'h0000, 6'h01, 1'b0);
    chk({7'h0, protect}, 8'h01);
    wr_pg(13'h0300, 3, 8'h5a, 1'b1, 1'b1);
    chk({7'h0, protect}, 8'h01);
    wr_pg(13'h0300, 2, 8'hc3, 1'b0, 1'b0);
    do_req(PEW_OP_UNLOCK, 13'h0000, 6'h01, 1'b0);
    chk({7'h0, protect}, 8'h00);
    wr_pg(13'h0300, 2, 8'hc3, 1'b0, 1'b1);
  endtask
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_op = PEW_OP_READ;
    req_addr = '0;
    req_len = '0;
    locked_mode = 1'b0;
    fill_valid = 1'b0;
    fill_idx = '0;
    fill_data = '0;
    slow = 1'b0;
    foreach (shadow[i]) shadow[i] = 8'hff;
    t_reset();
    wr_pg(13'h0120, 1, 8'h3c, 1'b0, 1'b1);
    wr_pg(13'h1fe0, 32, 8'h80, 1'b0, 1'b1);
    slow = 1'b1;
    wr_pg(13'h0a40, 5, 8'h11, 1'b0, 1'b1);
    slow = 1'b0;
    t_lock();
    print_verdict();
  end
endmodule // testbench
